/* dcm_pkg.sv */
// dcm_pkg: constants shared by the dc measurement unit
// assumes nothing beyond a standard systemverilog compiler
`default_nettype none
package dcm_pkg;

  // register indices within a page; byte address is four times the index
  localparam logic [6:0] IDX_PAGE      = 7'h00;
  localparam logic [6:0] IDX_CTRL_ONE  = 7'h66;
  localparam logic [6:0] IDX_CTRL_TWO  = 7'h67;
  localparam logic [6:0] IDX_LEFT_HI   = 7'h68;
  localparam logic [6:0] IDX_LEFT_MID  = 7'h69;
  localparam logic [6:0] IDX_LEFT_LO   = 7'h6a;
  localparam logic [6:0] IDX_RIGHT_HI  = 7'h6b;
  localparam logic [6:0] IDX_RIGHT_MID = 7'h6c;
  localparam logic [6:0] IDX_RIGHT_LO  = 7'h6d;

  // the page that holds the measurement registers
  localparam logic [7:0] PAGE_DC = 8'h00;

  // reset values
  localparam logic [7:0] RST_PAGE     = 8'h00;
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h00;

  // control one fields
  localparam int BIT_LEFT_EN  = 7;
  localparam int BIT_RIGHT_EN = 6;
  localparam int BIT_IIR_SEL  = 5;
  localparam int EXP_MSB      = 4;

  // control two fields
  localparam int BIT_FREEZE   = 6;
  localparam int BIT_CAPTURE  = 5;
  localparam int TIME_MSB     = 4;
  localparam logic [7:0] CTRL_TWO_MASK = 8'h7f;

  // exponent and averaging-time codes
  localparam logic [4:0] CODE_MAX  = 5'h14;
  localparam logic [4:0] CODE_ZERO = 5'h00;

  // datapath widths
  localparam int SAMPLE_W = 24;
  localparam int GUARD_W  = 20;
  localparam int ACC_W    = SAMPLE_W + GUARD_W;
  localparam int CNT_W    = 20;

endpackage

`default_nettype wire

/* dcm_top.sv */
// dcm_top: paged apb register file and two dc measurement channels
// assumes adc samples and a modulator tick arrive synchronous to REF_CLK_I
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

// one measurement channel: moving average or first order iir
// both filters share one accumulator, since only one runs at a time
// the result register is the only state software ever sees
module dcm_chan (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // configuration
  input  wire logic        en_i,
  input  wire logic        iir_sel_i,
  input  wire logic [4:0]  exp_i,
  input  wire logic        capture_i,
  input  wire logic        freeze_i,
  // sample stream
  input  wire logic        tick_i,
  input  wire logic        clear_i,
  input  wire logic [23:0] sample_i,
  // result
  output logic      [23:0] result_o
);

  // filter accumulator, block counter and visible result
  logic signed [dcm_pkg::ACC_W-1:0] acc_reg;
  logic signed [dcm_pkg::ACC_W-1:0] acc_next;
  logic        [dcm_pkg::CNT_W-1:0] cnt_reg;
  logic        [dcm_pkg::CNT_W-1:0] cnt_next;
  logic        [23:0]               result_reg;
  logic        [23:0]               result_next;

  // exponent code zero is reserved; it behaves as one sample
  // reserved codes are clamped so the shifters stay bounded
  wire  [4:0]  exp_eff = (exp_i > dcm_pkg::CODE_MAX) ? dcm_pkg::CODE_MAX : exp_i;
  wire  [20:0] span    = 21'h000001 << exp_eff;
  wire  [dcm_pkg::CNT_W-1:0] ma_last_cnt = 20'(span - 21'h000001);
  wire  ma_last = (cnt_reg == ma_last_cnt);
  wire  signed [dcm_pkg::ACC_W-1:0] x_ext =
    {{dcm_pkg::GUARD_W{sample_i[23]}}, sample_i};
  // moving average closes a block of 2^exponent samples
  wire  signed [dcm_pkg::ACC_W-1:0] ma_sum = acc_reg + x_ext;
  wire  [23:0] ma_out = 24'(ma_sum >>> exp_eff);
  // iir state carries exponent extra bits; output is state scaled down
  // a larger exponent gives a slower, smoother iir
  wire  signed [dcm_pkg::ACC_W-1:0] iir_y = acc_reg >>> exp_eff;
  wire  signed [dcm_pkg::ACC_W-1:0] iir_sum = acc_reg + x_ext - iir_y;
  wire  [23:0] iir_out = 24'(iir_y);
  wire  [23:0] iir_new = 24'(iir_sum >>> exp_eff);

  // next state of filter and result
  // a clear tick drops its sample so the state restarts from zero exactly
  // disable clears the filter but keeps the last result readable
  always_comb begin
    acc_next    = acc_reg;
    cnt_next    = cnt_reg;
    result_next = result_reg;
    if (!en_i) begin
      acc_next = '0;
      cnt_next = '0;
    end else if (iir_sel_i) begin
      cnt_next = '0;
      if (clear_i) begin
        acc_next = '0;
        if (capture_i && !freeze_i) begin
          result_next = iir_out;
        end
      end else if (tick_i) begin
        acc_next = iir_sum;
        if (!capture_i && !freeze_i) begin
          result_next = iir_new;
        end
      end
    end else if (tick_i) begin
      if (ma_last) begin
        acc_next = '0;
        cnt_next = '0;
        if (!freeze_i) begin
          result_next = ma_out;
        end
      end else begin
        acc_next = ma_sum;
        cnt_next = 20'(cnt_reg + 20'h00001);
      end
    end
  end

  // filter state; result holds its value across disable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_reg    <= '0;
      cnt_reg    <= '0;
      result_reg <= 24'h000000;
    end else begin
      acc_reg    <= acc_next;
      cnt_reg    <= cnt_next;
      result_reg <= result_next;
    end
  end

  // result drives the read mux directly
  assign result_o = result_reg;

endmodule

// top: paged apb register file, shared period counter, two channels
// every access takes one wait state so the answer comes from flops
// off page zero only the page register can be read or written
module dcm_top (
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RESET_N_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [8:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // adc sample stream
  input  wire logic        ADC_TICK_I,
  input  wire logic [23:0] ADC_LEFT_I,
  input  wire logic [23:0] ADC_RIGHT_I
);

  // synchroniser, registers, answer flops and channel results
  logic        rst_meta_reg;
  logic        rst_sync_reg;
  logic [7:0]  page_reg;
  logic [7:0]  ctrl_one_reg;
  logic [7:0]  ctrl_two_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [dcm_pkg::CNT_W-1:0] period_reg;
  logic [dcm_pkg::CNT_W-1:0] period_next;
  logic [23:0] left_res;
  logic [23:0] right_res;

  // reset release through two flops; the first feeds only the second
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // bus decode; one wait state so every output comes from a flop
  wire [6:0] idx      = PADDR_I[8:2];
  wire       misalign = (PADDR_I[1:0] != 2'h0);
  wire       acc_go   = PSEL_I & PENABLE_I & ~pready_reg;
  wire       acc_done = PSEL_I & PENABLE_I & pready_reg;
  wire       wr_ok    = acc_done & PWRITE_I & PSTRB_I[0] & ~pslverr_reg;
  wire       on_dc    = (page_reg == dcm_pkg::PAGE_DC);
  wire       wr_page  = wr_ok & (idx == dcm_pkg::IDX_PAGE);
  wire       wr_one   = wr_ok & on_dc & (idx == dcm_pkg::IDX_CTRL_ONE);
  wire       wr_two   = wr_ok & on_dc & (idx == dcm_pkg::IDX_CTRL_TWO);

  // read selection; reserved and foreign locations read zero
  // the page register answers on every page so software can get back
  wire [7:0] rd_byte =
    (idx == dcm_pkg::IDX_PAGE)                ? page_reg :
    !on_dc                                    ? 8'h00 :
    (idx == dcm_pkg::IDX_CTRL_ONE)            ? ctrl_one_reg :
    (idx == dcm_pkg::IDX_CTRL_TWO)            ? ctrl_two_reg :
    (idx == dcm_pkg::IDX_LEFT_HI)             ? left_res[23:16] :
    (idx == dcm_pkg::IDX_LEFT_MID)            ? left_res[15:8] :
    (idx == dcm_pkg::IDX_LEFT_LO)             ? left_res[7:0] :
    (idx == dcm_pkg::IDX_RIGHT_HI)            ? right_res[23:16] :
    (idx == dcm_pkg::IDX_RIGHT_MID)           ? right_res[15:8] :
    (idx == dcm_pkg::IDX_RIGHT_LO)            ? right_res[7:0] :
    8'h00;

  // apb handshake and read data
  // pslverr marks a misaligned address; such a write is dropped
  always_ff @(posedge REF_CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= acc_go;
      pslverr_reg <= acc_go & misalign;
      if (acc_go) begin
        prdata_reg <= misalign ? 32'h00000000 : {24'h000000, rd_byte};
      end
    end
  end

  // control registers; result bytes have no write path
  // control two drops its top bit so it always reads back zero
  always_ff @(posedge REF_CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      page_reg     <= dcm_pkg::RST_PAGE;
      ctrl_one_reg <= dcm_pkg::RST_CTRL_ONE;
      ctrl_two_reg <= dcm_pkg::RST_CTRL_TWO;
    end else begin
      if (wr_page) begin
        page_reg <= PWDATA_I[7:0];
      end
      if (wr_one) begin
        ctrl_one_reg <= PWDATA_I[7:0];
      end
      if (wr_two) begin
        ctrl_two_reg <= PWDATA_I[7:0] & dcm_pkg::CTRL_TWO_MASK;
      end
    end
  end

  // averaging period counter in modulator ticks
  // one counter serves both channels, so their clears stay aligned
  // reserved time codes clamp to the longest period rather than wrap
  wire [4:0]  t_code   = ctrl_two_reg[dcm_pkg::TIME_MSB:0];
  wire [4:0]  t_eff    = (t_code > dcm_pkg::CODE_MAX) ? dcm_pkg::CODE_MAX : t_code;
  wire [20:0] t_span   = 21'h000001 << t_eff;
  wire [dcm_pkg::CNT_W-1:0] t_last = 20'(t_span - 21'h000001);
  wire        iir_sel  = ctrl_one_reg[dcm_pkg::BIT_IIR_SEL];
  wire        finite   = (t_code != dcm_pkg::CODE_ZERO);
  wire        clr_now  = ADC_TICK_I & iir_sel & finite & (period_reg == t_last);

  // counter restarts whenever the period is off or has just closed
  always_comb begin
    period_next = period_reg;
    if (!iir_sel || !finite || clr_now) begin
      period_next = '0;
    end else if (ADC_TICK_I) begin
      period_next = 20'(period_reg + 20'h00001);
    end
  end

  // period counter state
  always_ff @(posedge REF_CLK_I or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      period_reg <= '0;
    end else begin
      period_reg <= period_next;
    end
  end

  // channel configuration straight from the control registers
  wire       left_en    = ctrl_one_reg[dcm_pkg::BIT_LEFT_EN];
  wire       right_en   = ctrl_one_reg[dcm_pkg::BIT_RIGHT_EN];
  wire [4:0] exp_code   = ctrl_one_reg[dcm_pkg::EXP_MSB:0];
  wire       capture_on = ctrl_two_reg[dcm_pkg::BIT_CAPTURE];
  wire       freeze_on  = ctrl_two_reg[dcm_pkg::BIT_FREEZE];

  // one channel instance per adc path
  // both channels see one tick, one clear and one set of filter settings; each has its own enable bit
  dcm_chan u_left (
    .clk_i     (REF_CLK_I),
    .rst_n_i   (rst_sync_reg),
    .en_i      (left_en),
    .iir_sel_i (iir_sel),
    .exp_i     (exp_code),
    .capture_i (capture_on),
    .freeze_i  (freeze_on),
    .tick_i    (ADC_TICK_I),
    .clear_i   (clr_now),
    .sample_i  (ADC_LEFT_I),
    .result_o  (left_res)
  );

  dcm_chan u_right (
    .clk_i     (REF_CLK_I),
    .rst_n_i   (rst_sync_reg),
    .en_i      (right_en),
    .iir_sel_i (iir_sel),
    .exp_i     (exp_code),
    .capture_i (capture_on),
    .freeze_i  (freeze_on),
    .tick_i    (ADC_TICK_I),
    .clear_i   (clr_now),
    .sample_i  (ADC_RIGHT_I),
    .result_o  (right_res)
  );

  // apb outputs come straight from their flops
  assign PRDATA_O  = prdata_reg;
  assign PREADY_O  = pready_reg;
  assign PSLVERR_O = pslverr_reg;

endmodule

`default_nettype wire

/* dcm_props.sv */
// dcm_props: apb answer checks for the dc measurement unit
// assumes binding to dcm_top and sight of its apb ports only
`timescale 1ns/100ps
`default_nettype none
module dcm_props (
  input wire logic        REF_CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [8:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O
);
  logic [7:0] pg_reg;
  // decode of the transfer that the design answers
  wire [6:0] idx   = PADDR_I[8:2];
  wire       rd_ok = PREADY_O && !PWRITE_I && !PSLVERR_O;
  wire       wr_pg = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O
                     && PSTRB_I[0] && (idx == 7'h00);
  // shadow page, so checks know which page a read hits
  always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) pg_reg <= 8'h00;
    else if (wr_pg) pg_reg <= PWDATA_I[7:0];
  end
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  property p_rdy; PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_pulse; PREADY_O |=> !PREADY_O; endproperty
  a_pulse: assert property (p_pulse) else $error("pready long");
  property p_err; PREADY_O |-> PSLVERR_O == (PADDR_I[1:0] != 2'h0); endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_err_rdy; PSLVERR_O |-> PREADY_O; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr alone");
  property p_upper; PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_page; rd_ok && idx == 7'h00 |-> PRDATA_O[7:0] == pg_reg; endproperty
  a_page: assert property (p_page) else $error("page readback");
  property p_resv; rd_ok && pg_reg == 8'h00 && idx >= 7'h6e |-> PRDATA_O == 32'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved not zero");
  property p_top; rd_ok && pg_reg == 8'h00 && idx == 7'h67 |-> !PRDATA_O[7]; endproperty
  a_top: assert property (p_top) else $error("ctrl two top bit");
  property p_other; rd_ok && pg_reg != 8'h00 && idx != 7'h00 |-> PRDATA_O == 32'h0; endproperty
  a_other: assert property (p_other) else $error("other page data");
endmodule
bind dcm_top dcm_props u_props (.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O));
`default_nettype wire

/* dcm_top_tb.sv */
// dcm_top_tb: apb register and filter tests for the dc measurement unit
// assumes dcm_pkg and dcm_top compiled first
`timescale 1ns/100ps
`default_nettype none
module dcm_top_tb;
  localparam logic [6:0] C1 = dcm_pkg::IDX_CTRL_ONE;
  localparam logic [6:0] C2 = dcm_pkg::IDX_CTRL_TWO;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        tk = 1'b0;
  logic [8:0]  padr = 9'h000;
  logic [31:0] pwd = 32'h0;
  logic [3:0]  pst = 4'h1;
  logic [23:0] al = 24'h0;
  logic [23:0] ar = 24'h0;
  logic [31:0] rdv;
  logic        erv;
  wire  [31:0] prd;
  wire         rdy;
  wire         err;
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  // byte strobe lane 0 gates every register write
  dcm_top dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PSTRB_I(pst), .PRDATA_O(prd),
    .PREADY_O(rdy), .PSLVERR_O(err), .ADC_TICK_I(tk), .ADC_LEFT_I(al), .ADC_RIGHT_I(ar));
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; pready is read before this edge's updates land
  task automatic apb(input logic w, input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    // only the cycle ceiling below ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rdv = prd;
    erv = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'h0}, d);
  endtask
  task automatic rd(input string nm, input logic [6:0] i, input logic [7:0] e);
    apb(1'b0, {i, 2'h0}, 8'h00);
    chk(nm, {24'h0, e}, rdv);
  endtask
  // both 24-bit results, msb byte at the lowest index
  task automatic both(input logic [23:0] l, input logic [23:0] r);
    for (int k = 0; k < 3; k++) begin
      rd("left", dcm_pkg::IDX_LEFT_HI + 7'(k), l[23 - 8 * k -: 8]);
      rd("right", dcm_pkg::IDX_RIGHT_HI + 7'(k), r[23 - 8 * k -: 8]);
    end
  endtask
  // right sample is the negation, which exercises sign handling
  task automatic feed(input logic [23:0] v, input int n);
    repeat (n) begin
      @(posedge clk);
      tk <= 1'b1;
      al <= v;
      ar <= -v;
    end
    @(posedge clk);
    tk <= 1'b0;
  endtask
  initial forever #2 clk = ~clk;
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 'h66; i <= 'h6d; i++) rd("reset", 7'(i), 8'h00);
    for (int i = 'h68; i <= 'h7f; i++) begin
      wr(7'(i), 8'hff);
      rd("readonly", 7'(i), 8'h00);
    end
    $display("test reset_readonly done");
    wr(C2, 8'hff);
    rd("ctrl2", C2, 8'h7f);
    wr(dcm_pkg::IDX_PAGE, 8'h01);
    rd("page", dcm_pkg::IDX_PAGE, 8'h01);
    rd("page1", C2, 8'h00);
    wr(dcm_pkg::IDX_PAGE, 8'h00);
    rd("page0", C2, 8'h7f);
    wr(C2, 8'h00);
    apb(1'b1, {C1, 2'h1}, 8'hff);
    chk("slverr", 32'h1, {31'h0, erv});
    pst <= 4'h0;
    wr(C1, 8'hff);
    pst <= 4'h1;
    rd("ctrl1", C1, 8'h00);
    $display("test registers done");
    wr(C1, 8'h82);
    feed(24'h8, 1);
    feed(24'h0, 3);
    both(24'h2, 24'h0);
    wr(C1, 8'hc2);
    feed(24'h10, 4);
    both(24'h10, 24'hfffff0);
    wr(C2, 8'h40);
    feed(24'h40, 4);
    both(24'h10, 24'hfffff0);
    wr(C2, 8'h00);
    feed(24'h40, 4);
    both(24'h40, 24'hffffc0);
    wr(C1, 8'h42);
    feed(24'h8, 4);
    both(24'h40, 24'hfffff8);
    $display("test average done");
    wr(C1, 8'h00);
    wr(C1, 8'he1);
    feed(24'h10, 3);
    both(24'he, 24'hfffff2);
    wr(C2, 8'h21);
    feed(24'h10, 6);
    both(24'h8, 24'hfffff8);
    $display("test iir done");
    close_out();
  end
endmodule
`default_nettype wire
